// File: rtl/sleep_gate_pkg.sv
package sleep_gate_pkg;
  // number of gated peripherals
  localparam int unsigned NUM_PERIPH = 32;
  // register byte offsets
  localparam logic [7:0] OFF_RUN_EN = 8'h00;
  localparam logic [7:0] OFF_SLEEP_EN = 8'h04;
  localparam logic [7:0] OFF_DEEP_EN = 8'h08;
  localparam logic [7:0] OFF_GATE_CTL = 8'h0c;
  localparam logic [7:0] OFF_READY = 8'h10;
  // field position of the global gating switch
  localparam int unsigned GATE_BIT = 0;
  // reset values
  localparam logic [31:0] RST_RUN_EN = 32'h0000_0000;
  localparam logic [31:0] RST_SLEEP_EN = 32'h0000_0000;
  localparam logic [31:0] RST_DEEP_EN = 32'h0000_0000;
  localparam logic RST_GATE = 1'b0;
  // enable to active delay, in cycles
  localparam logic [2:0] EN_DELAY_CYC = 3'h5;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // processor power modes
  typedef enum logic [1:0]
  {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP = 2'b10
  } power_mode_t;
endpackage

// File: rtl/sleep_clock_gate.sv
// Notes on behaviour
// RULE1 - With gating off, every peripheral is clocked in sleep and deep-sleep just as in run.
// RULE2 - With gating on, sleep and deep-sleep clocking follows each peripheral's own enable bits.
// RULE3 - With gating on, deep-sleep withholds the clock of a peripheral whose deep-sleep bit is 0.
// RULE4 - On leaving deep-sleep a run-enabled peripheral gets its clock back, state untouched.
// RULE5 - With gating off, deep-sleep bits stay stored but have no effect on clocking.
// RULE6 - A peripheral with its deep-sleep bit set keeps its clock throughout deep-sleep.
// RULE7 - One sleep bit and one deep-sleep bit per peripheral, chosen by the power mode.
// RULE8 - After reset every peripheral is off and not accessible until its run bit is set.
// RULE9 - A peripheral becomes active five cycles after its enable is written; earlier access faults.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sleep_clock_gate
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] power_mode,
  input wire logic [31:0] periph_access,
  output logic [31:0] periph_clk_en,
  output logic [31:0] periph_fault,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sleep_gate_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: address and data latched separately, answered once both held
  logic aw_hold_ff, nxt_aw_hold;
  logic w_hold_ff, nxt_w_hold;
  logic [7:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] run_en_ff, nxt_run_en;
  logic [31:0] sleep_en_ff, nxt_sleep_en;
  logic [31:0] deep_en_ff, nxt_deep_en;
  logic gate_ff, nxt_gate;
  logic [31:0] active;
  logic [2:0] bus_rdy_ff, nxt_bus_rdy;
  logic [31:0] clk_en_ff, nxt_clk_en;
  logic [31:0] fault_ff, nxt_fault;
  logic do_write;

  assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign nxt_bus_rdy = {!nxt_aw_hold, !nxt_w_hold, !nxt_rvalid};
  always_comb
  begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_run_en = run_en_ff;
    nxt_sleep_en = sleep_en_ff;
    nxt_deep_en = deep_en_ff;
    nxt_gate = gate_ff;
    if (s_axi_awvalid && !aw_hold_ff)
    begin
      nxt_aw_hold = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_ff)
    begin
      nxt_w_hold = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      // RULE7 per-peripheral mode bits
      unique case (aw_addr_ff)
        OFF_RUN_EN: nxt_run_en = merge(run_en_ff, w_data_ff, w_strb_ff);
        OFF_SLEEP_EN: nxt_sleep_en = merge(sleep_en_ff, w_data_ff, w_strb_ff);
        OFF_DEEP_EN: nxt_deep_en = merge(deep_en_ff, w_data_ff, w_strb_ff);
        OFF_GATE_CTL:
        begin
          if (w_strb_ff[0])
          begin
            nxt_gate = w_data_ff[GATE_BIT];
          end
        end
        OFF_READY: nxt_bresp = RESP_OKAY;
        default: nxt_bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid_ff && s_axi_bready)
    begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_RUN_EN: nxt_rdata = run_en_ff;
        OFF_SLEEP_EN: nxt_rdata = sleep_en_ff;
        OFF_DEEP_EN: nxt_rdata = deep_en_ff;
        OFF_GATE_CTL: nxt_rdata = {31'h0, gate_ff};
        OFF_READY: nxt_rdata = active;
        default:
        begin
          nxt_rdata = 32'h0;
          nxt_rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
      // RULE8 all off at reset
      run_en_ff <= RST_RUN_EN;
      sleep_en_ff <= RST_SLEEP_EN;
      deep_en_ff <= RST_DEEP_EN;
      gate_ff <= RST_GATE;
      bus_rdy_ff <= 3'h7;
    end
    else
    begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      run_en_ff <= nxt_run_en;
      sleep_en_ff <= nxt_sleep_en;
      deep_en_ff <= nxt_deep_en;
      gate_ff <= nxt_gate;
      bus_rdy_ff <= nxt_bus_rdy;
    end
  end

  assign s_axi_awready = bus_rdy_ff[2];
  assign s_axi_wready = bus_rdy_ff[1];
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = bus_rdy_ff[0];
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  //////////////////////////////////////////////////////////////////////////////
  // per-peripheral wake-up delay and clock selection
  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g++)
    begin : gen_periph
      logic [2:0] cnt_ff, nxt_cnt;
      logic sel;
      // RULE9 five-cycle activation delay
      always_comb
      begin
        nxt_cnt = cnt_ff;
        if (!run_en_ff[g])
        begin
          nxt_cnt = 3'h0;
        end
        else if (cnt_ff != EN_DELAY_CYC)
        begin
          nxt_cnt = cnt_ff + 3'h1;
        end
      end
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cnt_ff <= 3'h0;
        end
        else
        begin
          cnt_ff <= nxt_cnt;
        end
      end
      assign active[g] = (cnt_ff == EN_DELAY_CYC);
      // RULE1 RULE2 RULE3 RULE5 RULE6 mode select
      always_comb
      begin
        sel = active[g];
        if (gate_ff && power_mode == MODE_SLEEP)
        begin
          sel = active[g] && sleep_en_ff[g];
        end
        else if (gate_ff && power_mode == MODE_DEEP)
        begin
          sel = active[g] && deep_en_ff[g];
        end
      end
      assign nxt_clk_en[g] = sel;
      // RULE9 fault on early access
      assign nxt_fault[g] = periph_access[g] && !active[g];
    end
  endgenerate

  // RULE4 clock returns with run mode, peripheral state never reset here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_en_ff <= 32'h0;
      fault_ff <= 32'h0;
    end
    else
    begin
      clk_en_ff <= nxt_clk_en;
      fault_ff <= nxt_fault;
    end
  end
  assign periph_clk_en = clk_en_ff;
  assign periph_fault = fault_ff;

  //////////////////////////////////////////////////////////////////////////////
  gate_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1 RULE5
    !gate_ff |=> periph_clk_en == $past(active))
    else $error("gating off but clock differs from run");
  deep_stop_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3 RULE6
    gate_ff && power_mode == MODE_DEEP |=> periph_clk_en == $past(active & deep_en_ff))
    else $error("deep-sleep clock mismatch");
  sleep_sel_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2 RULE7
    gate_ff && power_mode == MODE_SLEEP |=> periph_clk_en == $past(active & sleep_en_ff))
    else $error("sleep clock mismatch");
  run_mode_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
    power_mode == MODE_RUN |=> periph_clk_en == $past(active))
    else $error("run-mode clock not restored");
  off_noclk_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
    (run_en_ff == 32'h0)[*2] |=> periph_clk_en == 32'h0)
    else $error("disabled peripheral clocked");
  delay_five_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
    $rose(run_en_ff[0]) ##1 run_en_ff[0] [*4] |=> active[0] && !$past(active[0]))
    else $error("activation delay not five cycles");
  early_fault_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
    periph_access[0] && !active[0] |=> periph_fault[0])
    else $error("early access not faulted");
  ready_fault_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
    active[0] |=> !periph_fault[0])
    else $error("fault on active peripheral");
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sleep_gate_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [1:0] power_mode = 2'h0;
  logic [31:0] periph_access = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] clk_en, fault, rdata, run, sl, dp, d, x;
  logic awready, wready, bvalid, arready, rvalid, g, ah, wh;
  logic [1:0] bresp, rresp, resp;
  int fails = 0;
  int comparisons = 0;
  int seed = 32'h7fd9;
  int n;

  sleep_clock_gate uut (.aclk(aclk), .aresetn(aresetn), .power_mode(power_mode),
    .periph_access(periph_access), .periph_clk_en(clk_en), .periph_fault(fault),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ////////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp}, "bus response");
  endtask

  // a hung handshake ends the run as a mismatch
  task lim;
    n++;
    if (n > 60)
    begin
      fails++;
      summarize();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    #1;
    while (awvalid || wvalid)
    begin
      ah = awvalid && awready === 1'b1;
      wh = wvalid && wready === 1'b1;
      @(posedge aclk);
      if (ah)
        awvalid <= 1'b0;
      if (wh)
        wvalid <= 1'b0;
      #1;
      lim();
    end
    while (bvalid !== 1'b1)
    begin
      @(posedge aclk);
      #1;
      lim();
    end
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    #1;
    while (arready !== 1'b1)
    begin
      @(posedge aclk);
      #1;
      lim();
    end
    @(posedge aclk);
    arvalid <= 1'b0;
    #1;
    while (rvalid !== 1'b1)
    begin
      @(posedge aclk);
      #1;
      lim();
    end
    v = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // one cycle of random accesses; only peripherals not yet ready fault
  task poke(input logic [31:0] rdy);
    @(posedge aclk);
    x = $random(seed);
    periph_access <= x;
    @(posedge aclk);
    periph_access <= 32'h0;
    #1;
    chk(fault, x & ~rdy, "access fault");
  endtask

  function automatic logic [31:0] exp_clk(input logic [1:0] m);
    if (!g || m == MODE_RUN || m == 2'b11)
      return run;
    return (m == MODE_SLEEP) ? (run & sl) : (run & dp);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(clk_en, 32'h0, "clock after reset");
    for (int a = 0; a < 5; a++)
    begin
      rd(8'(a * 4), d, resp);
      chk(d, 32'h0, "reset value");
      chk_resp(resp, RESP_OKAY);
    end
    rd(8'h20, d, resp);
    chk_resp(resp, RESP_SLVERR);
    wr(8'h24, 32'hffff_ffff, resp);
    chk_resp(resp, RESP_SLVERR);
    run = 32'h0;
    for (int k = 0; k < 8; k++)
    begin
      d = (k == 0) ? 32'hffff_ffff : $random(seed);
      sl = (k == 1) ? 32'h0 : $random(seed);
      dp = (k == 2) ? 32'hffff_ffff : $random(seed);
      g = k[0];
      wr(OFF_RUN_EN, d, resp);
      poke(run & d);
      repeat (8) @(posedge aclk);
      run = d;
      poke(run);
      rd(OFF_READY, x, resp);
      chk(x, run, "active status");
      wr(OFF_SLEEP_EN, sl, resp);
      wr(OFF_DEEP_EN, dp, resp);
      wr(OFF_GATE_CTL, {31'h0, g}, resp);
      // mode 3 after deep-sleep doubles as the wake-up case
      for (int m = 0; m < 4; m++)
      begin
        @(posedge aclk);
        power_mode <= m[1:0];
        repeat (3) @(posedge aclk);
        #1;
        chk(clk_en, exp_clk(m[1:0]), "clock enable");
      end
      rd(OFF_DEEP_EN, x, resp);
      chk(x, dp, "deep-sleep bits kept");
    end
    wr(OFF_READY, 32'h0, resp);
    chk_resp(resp, RESP_OKAY);
    rd(OFF_READY, x, resp);
    chk(x, run, "status is read-only");
    // partial strobes: unstrobed lanes keep their old bits
    wstrb <= 4'h5;
    wr(OFF_SLEEP_EN, ~sl, resp);
    rd(OFF_SLEEP_EN, x, resp);
    chk(x, (sl & 32'hff00_ff00) | (~sl & 32'h00ff_00ff), "sleep byte lanes");
    wstrb <= 4'he;
    wr(OFF_GATE_CTL, {31'h0, !g}, resp);
    rd(OFF_GATE_CTL, x, resp);
    chk(x, {31'h0, g}, "gating bit needs lane 0");
    wstrb <= 4'hf;
    // mid-run reset must drop the clock enables, the run bits and the active status
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(clk_en, 32'h0, "clock after second reset");
    rd(OFF_RUN_EN, x, resp);
    chk(x, 32'h0, "run bits after second reset");
    rd(OFF_READY, x, resp);
    chk(x, 32'h0, "status after second reset");
    summarize();
  end
endmodule
`default_nettype wire
